// file: src/sar_adc_pkg.sv
package sar_adc_pkg;
    localparam logic [5:0] REF_PIN_CFG_ADDR = 6'h13;
    localparam logic [5:0] ENABLE_CH_ADDR   = 6'h14;
    localparam logic [5:0] RESULT_LO_ADDR   = 6'h15;
    localparam logic [5:0] RESULT_HI_ADDR   = 6'h16;
    localparam logic [5:0] CONV_CTRL_ADDR   = 6'h17;
    localparam logic [5:0] IRQ_ENABLE_ADDR  = 6'h00;
    localparam logic [5:0] IRQ_REQUEST_ADDR = 6'h01;
    localparam int         CTRL_BIT3        = 3;
    localparam logic [3:0] REG_RESET        = 4'h0;
    localparam logic [8:0] SHORT_CONV_TAD   = 9'd50;
    localparam logic [8:0] LONG_CONV_TAD    = 9'd330;
    localparam int         RESULT_BITS      = 8;
    localparam int         CHANNELS         = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;
endpackage : sar_adc_pkg

// file: src/sar_adc_controller.sv
// Operation
// - Reference bit picks supply or external reference
// - Pin count field makes low pins analog
// - Channel field selects input zero to seven
// - Enable bit powers converter module
// - Result split into two read-only nibbles
// - Length bit selects 50 or 330 periods
// - Clock field divides oscillator by 1,2,4,8
// - Writing start begins conversion; reads busy
// - Start flag self-clears at conversion end
// - Completion raises converter interrupt request
// - Clearing start flag aborts conversion immediately
// - Abort leaves result registers unchanged
// - Analog pins lose digital function, pull-up
// - Runs during halt, stops on stop
// - Enabled completion wakes CPU from halt
// - Enable and request at bit three, reset zero
`timescale 1ns/100ps
module sar_adc_controller (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst,
    // Register port
    input  wire logic [5:0]                        addr,
    input  wire logic [3:0]                        wdata,
    input  wire logic                              wr,
    input  wire logic                              rd,
    output logic      [3:0]                        rdata,
    // CPU power state
    input  wire logic                              cpu_halted,
    input  wire logic                              cpu_stop,
    output logic                                   halt_wake,
    output logic                                   irq_active,
    // Analog front end
    output logic                                   reference_source_select,
    output logic                                   converter_power_on,
    output logic      [2:0]                        channel_select_field,
    output logic      [sar_adc_pkg::CHANNELS-1:0]  analog_pin_enable,
    output logic                                   sample_enable,
    output logic      [sar_adc_pkg::RESULT_BITS-1:0] dac_code,
    input  wire logic                              comparator_out
);
    import sar_adc_pkg::*;

    logic [3:0]  pin_cfg_q;
    logic [3:0]  en_ch_q;
    logic [2:0]  ctrl_low_q;
    logic        go_q;
    logic [7:0]  result_q;
    logic        irq_en_q;
    logic        irq_req_q;
    conv_state_t state_q;
    logic [2:0]  div_cnt_q;
    logic [8:0]  tad_cnt_q;
    logic [7:0]  sar_q;
    logic [7:0]  trial_q;
    logic        cmp_s1_q;
    logic        cmp_s2_q;
    logic        tad_tick;
    logic [2:0]  div_max;
    logic [8:0]  conv_len;
    logic        wr_ctrl;
    logic        start;
    logic        abort;
    logic        done;
    logic [8:0]  sar_end;
    logic [7:0]  sar_next;
    logic [11:0] conv_cycles_q;
    logic [11:0] expected_cycles;

    assign reference_source_select = pin_cfg_q[CTRL_BIT3];
    assign converter_power_on      = en_ch_q[CTRL_BIT3];
    assign channel_select_field    = en_ch_q[2:0];

    // Pin k analog when k below configured count; code 7 covers all eight
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_pin
            assign analog_pin_enable[gi] = (pin_cfg_q[2:0] == 3'h7) ||
                                           (3'(gi) < pin_cfg_q[2:0]);
        end
    endgenerate

    // Divider: 1, 2, 4 or 8 oscillator periods per converter period
    always_comb begin
        case (ctrl_low_q[2:1])
            2'b00:   div_max = 3'h0;
            2'b01:   div_max = 3'h1;
            2'b10:   div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
    end
    assign conv_len = ctrl_low_q[0] ? LONG_CONV_TAD : SHORT_CONV_TAD;
    // Compare with >= so a smaller divider written mid-run cannot wrap the counter
    assign tad_tick = (state_q == ST_CONV) && (div_cnt_q >= div_max);

    assign wr_ctrl = wr && (addr == CONV_CTRL_ADDR);
    assign start   = wr_ctrl && wdata[CTRL_BIT3] && converter_power_on && (state_q == ST_IDLE)
                     && !cpu_stop;
    // Stop instruction or module power-down abandon the conversion as well
    assign abort   = (state_q == ST_CONV) &&
                     ((wr_ctrl && !wdata[CTRL_BIT3]) || cpu_stop || !converter_power_on);
    assign done    = tad_tick && (tad_cnt_q == conv_len - 9'd1) && !abort;

    // The last eight converter periods each resolve one bit, MSB first
    assign sar_end = conv_len - 9'd8;

    // Trial bit is kept when the synchronised comparator sees the input at or above the code
    assign sar_next = cmp_s2_q ? (sar_q | trial_q) : sar_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= comparator_out;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_cfg_q  <= REG_RESET;
            en_ch_q    <= REG_RESET;
            ctrl_low_q <= 3'h0;
        end else if (wr) begin
            if (addr == REF_PIN_CFG_ADDR) pin_cfg_q <= wdata;
            if (addr == ENABLE_CH_ADDR)   en_ch_q   <= wdata;
            if (wr_ctrl)                  ctrl_low_q <= wdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            go_q      <= 1'b0;
            div_cnt_q <= 3'h0;
            tad_cnt_q <= 9'h0;
            sar_q     <= 8'h00;
            trial_q   <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q   <= ST_CONV;
                        go_q      <= 1'b1;
                        div_cnt_q <= 3'h0;
                        tad_cnt_q <= 9'h0;
                        sar_q     <= 8'h00;
                        trial_q   <= 8'h80;
                    end
                end
                ST_CONV: begin
                    if (abort || done) begin
                        state_q <= ST_IDLE;
                        go_q    <= 1'b0;
                    end else begin
                        div_cnt_q <= tad_tick ? 3'h0 : div_cnt_q + 3'h1;
                        if (tad_tick) begin
                            tad_cnt_q <= tad_cnt_q + 9'h1;
                            if (tad_cnt_q >= sar_end) begin
                                sar_q <= sar_next;
                                trial_q <= trial_q >> 1;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    go_q    <= 1'b0;
                end
            endcase
        end
    end

    // Final result, both nibbles taken together; abort skips this
    // The LSB resolves in the done cycle itself, so take it from sar_next
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_q <= 8'h00;
        end else if (done) begin
            result_q <= sar_next;
        end
    end

    // Completion sets the request; a set in the clearing cycle wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_en_q  <= 1'b0;
            irq_req_q <= 1'b0;
        end else begin
            if (wr && addr == IRQ_ENABLE_ADDR) irq_en_q <= wdata[CTRL_BIT3];
            if (done) begin
                irq_req_q <= 1'b1;
            end else if (wr && addr == IRQ_REQUEST_ADDR) begin
                irq_req_q <= wdata[CTRL_BIT3];
            end
        end
    end

    assign irq_active    = irq_en_q && irq_req_q;
    assign halt_wake     = irq_active && cpu_halted;
    assign sample_enable = (state_q == ST_CONV) && (tad_cnt_q < sar_end);
    assign dac_code      = sar_q | trial_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 4'h0;
        end else if (rd) begin
            case (addr)
                REF_PIN_CFG_ADDR: rdata <= pin_cfg_q;
                ENABLE_CH_ADDR:   rdata <= en_ch_q;
                RESULT_LO_ADDR:   rdata <= result_q[3:0];
                RESULT_HI_ADDR:   rdata <= result_q[7:4];
                CONV_CTRL_ADDR:   rdata <= {go_q, ctrl_low_q};
                IRQ_ENABLE_ADDR:  rdata <= {irq_en_q, 3'h0};
                IRQ_REQUEST_ADDR: rdata <= {irq_req_q, 3'h0};
                default:          rdata <= 4'h0;
            endcase
        end else begin
            rdata <= 4'h0;
        end
    end

    // Assertion helper: an independent count of oscillator periods per conversion
    assign expected_cycles = {3'h0, conv_len} * ({9'h000, div_max} + 12'h001);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_cycles_q <= 12'h000;
        end else if (start) begin
            conv_cycles_q <= 12'h001;
        end else if (state_q == ST_CONV) begin
            conv_cycles_q <= conv_cycles_q + 12'h001;
        end
    end

    sequence start_seq;
        start;
    endsequence

    sequence done_seq;
        done;
    endsequence

    sequence abort_seq;
        abort;
    endsequence

    sequence idle_seq;
        state_q == ST_IDLE && !go_q;
    endsequence

    // Flag and state machine agree at all times
    go_state_a: assert property (@(posedge clock) disable iff (rst)
        go_q == (state_q == ST_CONV))
        else $error("flag and state disagree");
    sample_phase_a: assert property (@(posedge clock) disable iff (rst)
        start_seq |=> sample_enable && trial_q == 8'h80 && sar_q == 8'h00)
        else $error("conversion did not open with sampling");

    // Refused starts, aborts and running on through halt
    off_refused_a: assert property (@(posedge clock) disable iff (rst)
        wr_ctrl && wdata[CTRL_BIT3] && !converter_power_on && state_q == ST_IDLE |=> idle_seq)
        else $error("start accepted while powered down");
    stop_refused_a: assert property (@(posedge clock) disable iff (rst)
        wr_ctrl && cpu_stop && state_q == ST_IDLE |=> idle_seq)
        else $error("start accepted in stop");
    power_abort_a: assert property (@(posedge clock) disable iff (rst)
        state_q == ST_CONV && !converter_power_on |=> idle_seq)
        else $error("conversion kept running while powered down");
    abort_idle_a: assert property (@(posedge clock) disable iff (rst)
        abort_seq |=> idle_seq)
        else $error("abort did not return to idle");
    halt_runs_a: assert property (@(posedge clock) disable iff (rst)
        state_q == ST_CONV && cpu_halted && !abort && !done |=> state_q == ST_CONV)
        else $error("halt stopped the conversion");

    // Timing of the converter clock and the conversion length
    length_a: assert property (@(posedge clock) disable iff (rst)
        done_seq |-> conv_cycles_q == expected_cycles)
        else $error("conversion length wrong");
    div_restart_a: assert property (@(posedge clock) disable iff (rst)
        tad_tick |=> div_cnt_q == 3'h0 || state_q == ST_IDLE)
        else $error("divider not restarted");
    div_step_a: assert property (@(posedge clock) disable iff (rst)
        state_q == ST_CONV && !tad_tick && !abort |=> div_cnt_q == $past(div_cnt_q) + 3'h1)
        else $error("divider skipped a period");

    // Result, request and read data registers
    result_hold_a: assert property (@(posedge clock) disable iff (rst)
        !done |=> $stable(result_q))
        else $error("result changed without completion");
    irq_source_a: assert property (@(posedge clock) disable iff (rst)
        $rose(irq_req_q) |-> $past(done) || $past(wr && addr == IRQ_REQUEST_ADDR))
        else $error("request raised without cause");
    irq_clear_a: assert property (@(posedge clock) disable iff (rst)
        wr && addr == IRQ_REQUEST_ADDR && !wdata[CTRL_BIT3] && !done |=> !irq_req_q)
        else $error("request not cleared");
    idle_read_a: assert property (@(posedge clock) disable iff (rst)
        !rd |=> rdata == 4'h0)
        else $error("read data outside read cycle");

    // Pin configuration
    all_analog_a: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_q[2:0] == 3'h7 |-> analog_pin_enable == 8'hFF)
        else $error("pins not all analog at top code");
    first_pin_a: assert property (@(posedge clock) disable iff (rst)
        analog_pin_enable[0] == (pin_cfg_q[2:0] != 3'h0))
        else $error("first pin analog state wrong");

    busy_after_start_a: assert property (@(posedge clock) disable iff (rst)
        start_seq |=> go_q && state_q == ST_CONV)
        else $error("flag not set after start");
    done_clears_a: assert property (@(posedge clock) disable iff (rst)
        done |=> !go_q)
        else $error("flag stuck after done");
    done_irq_a: assert property (@(posedge clock) disable iff (rst)
        done |=> irq_req_q)
        else $error("request missing after done");
    abort_stop_a: assert property (@(posedge clock) disable iff (rst)
        abort |=> state_q == ST_IDLE && !go_q)
        else $error("abort ignored");
    abort_keeps_a: assert property (@(posedge clock) disable iff (rst)
        abort |=> $stable(result_q))
        else $error("result changed on abort");
    result_update_a: assert property (@(posedge clock) disable iff (rst)
        done |=> result_q == $past(sar_next))
        else $error("result not loaded");
    wake_a: assert property (@(posedge clock) disable iff (rst)
        irq_en_q && irq_req_q && cpu_halted |-> halt_wake)
        else $error("no wake");
    all_pins_a: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_q[2:0] == 3'h0 |-> analog_pin_enable == 8'h00)
        else $error("pins analog at zero");
    stop_halts_a: assert property (@(posedge clock) disable iff (rst)
        cpu_stop |=> state_q == ST_IDLE)
        else $error("runs in stop");
endmodule : sar_adc_controller

// file: test/analog_front_model.sv
`timescale 1ns/100ps
module analog_front_model (
    // Converter side
    input  wire logic       clock,
    input  wire logic       converter_power_on,
    input  wire logic [2:0] channel_select_field,
    input  wire logic [7:0] dac_code,
    // Comparator
    output logic            comparator_out
);
    logic       flip_q = 1'b0;
    logic [7:0] level;
    // An unpowered comparator has no defined output, so it wanders
    always_ff @(posedge clock) begin
        flip_q <= ~flip_q;
    end
    assign level = 8'h17 + 8'h1D * {5'h00, channel_select_field};
    // Pins feeding these levels are inputs, and the ideal comparator settles at once
    assign comparator_out = converter_power_on ? (level >= dac_code) : flip_q;
endmodule : analog_front_model

// file: test/sar_adc_controller_tb.sv
`timescale 1ns/100ps
module sar_adc_controller_tb;
    import sar_adc_pkg::*;
    logic       clock = 0, rst = 1, wr = 0, rd = 0, cpu_halted = 0, cpu_stop = 0;
    logic [5:0] addr = 6'h00;
    logic [3:0] wdata = 4'h0, rdata;
    logic       halt_wake, irq_active, ref_sel, power, sample_enable, comparator_out;
    logic [2:0] chan;
    logic [7:0] pins, dac_code;
    int         n_errors = 0, samples_checked = 0;
    always #50 clock = ~clock;
    sar_adc_controller uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cpu_halted(cpu_halted), .cpu_stop(cpu_stop), .halt_wake(halt_wake),
        .irq_active(irq_active), .reference_source_select(ref_sel), .converter_power_on(power),
        .channel_select_field(chan), .analog_pin_enable(pins), .sample_enable(sample_enable),
        .dac_code(dac_code), .comparator_out(comparator_out));
    analog_front_model far (.clock(clock), .converter_power_on(power), .channel_select_field(chan),
        .dac_code(dac_code), .comparator_out(comparator_out));
    function logic [7:0] lvl(input logic [2:0] ch);
        return 8'h17 + 8'h1D * {5'h00, ch};
    endfunction : lvl
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task wr_reg(input logic [5:0] a, input logic [3:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [5:0] a, output logic [3:0] v);
        @(posedge clock);
        addr <= a; rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask : rd_reg
    task check_resets;
        logic [3:0] v;
        wr_reg(RESULT_LO_ADDR, 4'hF);
        rd_reg(RESULT_LO_ADDR, v); chk("result lo ro", {4'h0, v}, 8'h00);
        rd_reg(REF_PIN_CFG_ADDR, v); chk("cfg reset", {4'h0, v}, 8'h00);
        rd_reg(CONV_CTRL_ADDR, v); chk("ctrl reset", {4'h0, v}, 8'h00);
        rd_reg(IRQ_ENABLE_ADDR, v); chk("irq en reset", {4'h0, v}, 8'h00);
        rd_reg(IRQ_REQUEST_ADDR, v); chk("irq req reset", {4'h0, v}, 8'h00);
        rd_reg(6'h3F, v); chk("unmapped", {4'h0, v}, 8'h00);
    endtask : check_resets
    task check_config;
        logic [3:0] v;
        for (int k = 0; k < 8; k++) begin
            wr_reg(REF_PIN_CFG_ADDR, {k[0], k[2:0]});
            wr_reg(ENABLE_CH_ADDR, {k[1], k[2:0]});
            rd_reg(REF_PIN_CFG_ADDR, v);
            chk("pins", pins, k == 7 ? 8'hFF : 8'((1 << k) - 1));
            chk("ref", {7'h00, ref_sel}, {7'h00, k[0]});
            chk("power", {7'h00, power}, {7'h00, k[1]});
            chk("chan", {5'h00, chan}, {5'h00, k[2:0]});
        end
    endtask : check_config
    task check_convert(input logic [3:0] ctrl, input int exp_cyc, input logic [2:0] ch);
        logic [3:0] v, lo;
        int n;
        repeat (4) @(posedge clock);
        wr_reg(ENABLE_CH_ADDR, {1'b1, ch});
        wr_reg(IRQ_REQUEST_ADDR, 4'h0);
        wr_reg(CONV_CTRL_ADDR, ctrl);
        n = 0;
        rd_reg(CONV_CTRL_ADDR, v);
        chk("busy", {4'h0, v}, {4'h0, ctrl});
        chk("sampling", {7'h00, sample_enable}, 8'h01);
        chk("first trial", dac_code, 8'h80);
        while (v[3] && n < 4000) begin
            rd_reg(CONV_CTRL_ADDR, v);
            n += 2;
        end
        if (n >= 4000) begin
            n_errors++;
            report_and_stop;
        end
        chk("length", 8'(n >= exp_cyc - 4 && n <= exp_cyc + 4), 8'h01);
        chk("done", {4'h0, v}, {4'h0, ctrl & 4'h7});
        chk("sample off", {7'h00, sample_enable}, 8'h00);
        rd_reg(RESULT_LO_ADDR, lo);
        rd_reg(RESULT_HI_ADDR, v);
        chk("result", {v, lo}, lvl(ch));
        rd_reg(IRQ_REQUEST_ADDR, v);
        chk("irq req", {4'h0, v}, 8'h08);
    endtask : check_convert
    task check_wake;
        @(posedge clock);
        cpu_halted <= 1'b1;
        wr_reg(IRQ_ENABLE_ADDR, 4'h8);
        check_convert(4'hE, 400, 3'd5);
        chk("wake", {6'h00, halt_wake, irq_active}, 8'h03);
        wr_reg(IRQ_REQUEST_ADDR, 4'h0);
        @(negedge clock);
        chk("wake off", {7'h00, halt_wake}, 8'h00);
        @(posedge clock);
        cpu_halted <= 1'b0;
    endtask : check_wake
    task check_abort;
        logic [3:0] v, lo;
        wr_reg(ENABLE_CH_ADDR, 4'hF);
        wr_reg(CONV_CTRL_ADDR, 4'hC);
        repeat (185) @(posedge clock);
        wr_reg(CONV_CTRL_ADDR, 4'h4);
        rd_reg(CONV_CTRL_ADDR, v); chk("abort", {4'h0, v}, 8'h04);
        repeat (200) @(posedge clock);
        rd_reg(RESULT_LO_ADDR, lo);
        rd_reg(RESULT_HI_ADDR, v); chk("kept", {v, lo}, lvl(3'd5));
        rd_reg(IRQ_REQUEST_ADDR, v); chk("no irq", {4'h0, v}, 8'h00);
    endtask : check_abort
    task check_refusals;
        logic [3:0] v;
        wr_reg(ENABLE_CH_ADDR, 4'h7);
        wr_reg(CONV_CTRL_ADDR, 4'hC);
        rd_reg(CONV_CTRL_ADDR, v); chk("off start", {4'h0, v}, 8'h04);
        wr_reg(ENABLE_CH_ADDR, 4'hF);
        cpu_stop <= 1'b1;
        wr_reg(CONV_CTRL_ADDR, 4'hC);
        rd_reg(CONV_CTRL_ADDR, v); chk("stop start", {4'h0, v}, 8'h04);
        @(posedge clock);
        cpu_stop <= 1'b0;
    endtask : check_refusals
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        check_resets;
        check_config;
        check_convert(4'hC, 200, 3'd2);
        check_convert(4'hD, 1320, 3'd7);
        check_wake;
        check_abort;
        check_refusals;
        report_and_stop;
    end
endmodule : sar_adc_controller_tb
